//--- hw/icc_unit.sv
// Input capture unit: several channels, each with synchroniser, edge
// detector, prescaler, four-entry FIFO and interrupt counter.
// Assumes the timer counts are in the system clock domain and the pins are not.
//
// Timing of one capture, counted in rising clock edges after the pin moves:
// the first three edges fill the synchroniser, the comb logic decides the
// capture once the second and third stages agree, and the edge after that
// stores the timestamp, bumps the fill count and, if the interrupt count is reached, pulses the interrupt.
// A pin level must therefore be sampled at two successive rising edges to be
// seen; shorter glitches are filtered out by the agreement test.
//
// Each channel keeps its own buffer, overflow flag and interrupt counter,
// so channels never interfere with one another. Only the wake request is
// shared: any channel that sees an event while the processor sleeps asks
// for wake-up.
`timescale 1ns/10ps
module icc_unit #(
	parameter int CHANNELS = 8,
	parameter int DMA_CHANNELS = 2
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [CHANNELS-1:0] capture_input_pin,
	input wire logic [icc_pkg::TIME_W-1:0] first_time_base,
	input wire logic [icc_pkg::TIME_W-1:0] second_time_base,
	input wire icc_pkg::icc_ctrl_s [CHANNELS-1:0] ctrl,
	input wire logic [CHANNELS-1:0] read_pop,
	input wire logic [CHANNELS-1:0] overflow_clear,
	input wire logic cpu_asleep,
	output icc_pkg::icc_stat_s [CHANNELS-1:0] status,
	output logic [CHANNELS-1:0] irq,
	output logic [CHANNELS-1:0] dma_request,
	output logic wake_request
);

	logic [CHANNELS-1:0] event_any;

	////////////////////////////////////////////////////////////////////////////
	// One independent slice per channel.
	// Mode codes: off clears the prescaler and the interrupt counter; both,
	// fall and rise capture on the named pin edges; the two prescaled modes
	// capture on every fourth or sixteenth rising edge; the interrupt-only
	// mode pulses the interrupt on each rising edge without touching the
	// buffer, which lets the pin serve as a plain external interrupt. The
	// one unused code captures nothing, but unlike off it keeps its counters.
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
			logic [2:0] sync_reg, sync_next;
			logic [icc_pkg::PRE_W-1:0] pre_reg, pre_next;
			logic [icc_pkg::TIME_W-1:0] mem_reg [icc_pkg::FIFO_DEPTH];
			logic [icc_pkg::TIME_W-1:0] mem_next [icc_pkg::FIFO_DEPTH];
			logic [icc_pkg::PTR_W-1:0] wr_reg, wr_next, rd_reg, rd_next;
			logic [icc_pkg::CNT_W-1:0] fill_reg, fill_next;
			logic [icc_pkg::CNT_W-1:0] since_reg, since_next;
			logic ov_reg, ov_next, irq_reg, irq_next, dma_reg, dma_next;
			logic level_reg, level_next;
			logic rise, fall, capture, push, pop, full;
			logic [icc_pkg::TIME_W-1:0] stamp;
			logic [icc_pkg::CNT_W-1:0] thresh;
			icc_pkg::icc_mode_e mode;

			// Edges are taken only once the second and third stages agree.
			// The held level changes only on agreement, so a pin that bounces
			// inside the synchroniser cannot produce two events for one edge.
			// Reset holds the level low, matching an idle low pin.
			always_comb begin
				mode = ctrl[ch].mode;
				sync_next = {sync_reg[1:0], capture_input_pin[ch]};
				level_next = level_reg;
				if (sync_reg[1] == sync_reg[2]) begin
					level_next = sync_reg[2];
				end
				rise = level_next & ~level_reg;
				fall = ~level_next & level_reg;
				pre_next = pre_reg;
				capture = 1'b0;
				// The prescaler counts only in its two modes; moving to any mode
				// but off keeps the count, so software should pass through off
				// when it wants a fresh count of four or sixteen rising edges.
				unique case (mode)
					icc_pkg::ICC_MODE_OFF: pre_next = '0;
					icc_pkg::ICC_MODE_BOTH: capture = rise | fall;
					icc_pkg::ICC_MODE_FALL: capture = fall;
					icc_pkg::ICC_MODE_RISE: capture = rise;
					icc_pkg::ICC_MODE_PRE4: begin
						if (rise) begin
							pre_next = (pre_reg == icc_pkg::PRE_FOUR_LAST) ? '0 : pre_reg + 4'h1;
							capture = (pre_reg == icc_pkg::PRE_FOUR_LAST);
						end
					end
					icc_pkg::ICC_MODE_PRE16: begin
						if (rise) begin
							pre_next = pre_reg + 4'h1;
							capture = (pre_reg == icc_pkg::PRE_SIXTEEN_LAST);
						end
					end
					icc_pkg::ICC_MODE_WAKE: capture = rise;
					default: capture = 1'b0;
				endcase
			end

			// FIFO, overflow flag and interrupt counter.
			always_comb begin
				stamp = ctrl[ch].timer_select ? second_time_base : first_time_base;
				thresh = {1'b0, ctrl[ch].interrupt_count_select} + 3'h1;
				full = (fill_reg == icc_pkg::CNT_W'(icc_pkg::FIFO_DEPTH));
				// A pop of an empty buffer is ignored, so a stray read cannot
				// wrap the read pointer past the write pointer.
				pop = read_pop[ch] && (fill_reg != 3'h0);
				// A capture that meets a full buffer is dropped rather than
				// overwriting the oldest entry, so software always reads the first
				// four timestamps after the buffer was last drained.
				push = capture && (mode != icc_pkg::ICC_MODE_WAKE) && !full;
				for (int i = 0; i < icc_pkg::FIFO_DEPTH; i++) begin
					mem_next[i] = mem_reg[i];
				end
				wr_next = wr_reg;
				rd_next = rd_reg;
				if (push) begin
					mem_next[wr_reg] = stamp;
					wr_next = wr_reg + 2'h1;
				end
				if (pop) begin
					rd_next = rd_reg + 2'h1;
				end
				fill_next = fill_reg + {2'h0, push} - {2'h0, pop};
				// A new overflow wins over a clear in the same cycle.
				ov_next = (ov_reg && !overflow_clear[ch]) ||
					(capture && mode != icc_pkg::ICC_MODE_WAKE && full);
				// The interrupt counter counts stored entries only; dropped
				// captures do not advance it, and interrupt-only mode bypasses it.
				since_next = since_reg;
				irq_next = 1'b0;
				if (mode == icc_pkg::ICC_MODE_WAKE) begin
					irq_next = capture;
				end else if (push) begin
					if (since_reg + 3'h1 >= thresh) begin
						since_next = '0;
						irq_next = 1'b1;
					end else begin
						since_next = since_reg + 3'h1;
					end
				end
				if (mode == icc_pkg::ICC_MODE_OFF) begin
					since_next = '0;
				end
				// The DMA request mirrors the interrupt on the low channels only;
				// with a count of one it asks for one transfer per stored entry.
				dma_next = (ch < DMA_CHANNELS) ? irq_next : 1'b0;
			end

			// Synchroniser, held level and prescaler of this channel.
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					sync_reg <= '0;
					level_reg <= 1'b0;
					pre_reg <= '0;
				end else begin
					sync_reg <= sync_next;
					level_reg <= level_next;
					pre_reg <= pre_next;
				end
			end

			// Buffer, pointers, counters and pulse outputs of this channel.
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					for (int i = 0; i < icc_pkg::FIFO_DEPTH; i++) begin
						mem_reg[i] <= '0;
					end
					wr_reg <= '0;
					rd_reg <= '0;
					fill_reg <= '0;
					since_reg <= '0;
					ov_reg <= 1'b0;
					irq_reg <= 1'b0;
					dma_reg <= 1'b0;
				end else begin
					for (int i = 0; i < icc_pkg::FIFO_DEPTH; i++) begin
						mem_reg[i] <= mem_next[i];
					end
					wr_reg <= wr_next;
					rd_reg <= rd_next;
					fill_reg <= fill_next;
					since_reg <= since_next;
					ov_reg <= ov_next;
					irq_reg <= irq_next;
					dma_reg <= dma_next;
				end
			end

			// Oldest entry is presented while the buffer holds data.
			// The read mux sits on stored words only, so read data never
			// changes except at a clock edge that pushes or pops.
			assign status[ch].read_data = mem_reg[rd_reg];
			assign status[ch].buffer_not_empty = (fill_reg != 3'h0);
			assign status[ch].capture_overflow_flag = ov_reg;
			assign irq[ch] = irq_reg;
			assign dma_request[ch] = dma_reg;
			// Every detected event of this channel feeds the shared wake logic.
			assign event_any[ch] = capture;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Any capture event while asleep asks for wake-up.
	// Events count even when the buffer is full, since the processor must
	// wake to drain it; the request is a one-cycle registered pulse.
	logic wake_reg, wake_next;

	always_comb begin
		wake_next = cpu_asleep && (|event_any);
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wake_reg <= 1'b0;
		end else begin
			wake_reg <= wake_next;
		end
	end

	assign wake_request = wake_reg;

endmodule // icc_unit

//--- hw/icc_pkg.sv
// Constants and carrier types of the input capture unit.
// Assumes a single 50 MHz system clock and an asynchronous active-low reset.
package icc_pkg;

	localparam int TIME_W = 16;
	localparam int FIFO_DEPTH = 4;
	localparam int PTR_W = 2;
	localparam int CNT_W = 3;
	localparam int PRE_W = 4;
	localparam logic [3:0] PRE_FOUR_LAST = 4'h3;
	localparam logic [3:0] PRE_SIXTEEN_LAST = 4'hF;
	localparam logic [1:0] ICNT_EVERY_ONE = 2'h0;

	// Capture mode field; code 000 turns the channel off.
	typedef enum logic [2:0] {
		ICC_MODE_OFF = 3'b000,
		ICC_MODE_BOTH = 3'b001,
		ICC_MODE_FALL = 3'b010,
		ICC_MODE_RISE = 3'b011,
		ICC_MODE_PRE4 = 3'b100,
		ICC_MODE_PRE16 = 3'b101,
		ICC_MODE_WAKE = 3'b111
	} icc_mode_e;

	// Per-channel software control.
	typedef struct packed {
		icc_mode_e mode;
		logic timer_select;
		logic [1:0] interrupt_count_select;
	} icc_ctrl_s;

	// Per-channel status seen by software.
	typedef struct packed {
		logic capture_overflow_flag;
		logic buffer_not_empty;
		logic [TIME_W-1:0] read_data;
	} icc_stat_s;

endpackage

//--- tb/icc_assertions.sv
// Port checker for the capture unit.
// Assumes channels 0 and 1 share pin and control, and three channels.
`timescale 1ns/10ps
module icc_assertions #(
	parameter int CHANNELS = 3
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [CHANNELS-1:0] capture_input_pin,
	input wire icc_pkg::icc_ctrl_s [CHANNELS-1:0] ctrl,
	input wire logic [CHANNELS-1:0] overflow_clear,
	input wire logic cpu_asleep,
	input wire icc_pkg::icc_stat_s [CHANNELS-1:0] status,
	input wire logic [CHANNELS-1:0] irq,
	input wire logic [CHANNELS-1:0] dma_request,
	input wire logic wake_request
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	wire icc_pkg::icc_stat_s s0 = status[0];
	////////////////////////////////////////////////////////////////////////
	a_dma_follows: assert property (dma_request[0] == irq[0]) else $error("dma bad");
	a_dma_none: assert property (!dma_request[2]) else $error("dma on ch2");
	a_irq_once: assert property (irq[0] |=> !irq[0]) else $error("irq long");
	a_irq_edge: assert property (
		irq[0] |-> $past(capture_input_pin[0], 3) != $past(capture_input_pin[0], 7))
		else $error("irq without edge");
	a_ovf_holds: assert property (
		s0.capture_overflow_flag && !overflow_clear[0] |=> s0.capture_overflow_flag)
		else $error("overflow lost");
	a_ovf_full: assert property (
		$rose(s0.capture_overflow_flag) |-> $past(s0.buffer_not_empty))
		else $error("overflow not full");
	a_wake_sleep: assert property (wake_request |-> $past(cpu_asleep)) else $error("wake");
	a_off_quiet: assert property ((ctrl[0].mode == 3'h0)[*4] |-> !irq[0])
		else $error("irq while off");
	a_irq_entry: assert property (
		irq[0] && ctrl[0].mode != 3'h7 |-> s0.buffer_not_empty) else $error("irq empty");
	a_chan_same: assert property (irq[1] == irq[0]) else $error("channels differ");
	c_irq: cover property (irq[0]);
	c_ovf: cover property ($rose(s0.capture_overflow_flag));
	c_wake: cover property (wake_request);
endmodule // icc_assertions
bind icc_unit icc_assertions #(.CHANNELS(CHANNELS)) chk (.clock(clock), .rstn(rstn),
	.capture_input_pin(capture_input_pin), .ctrl(ctrl), .overflow_clear(overflow_clear),
	.cpu_asleep(cpu_asleep), .status(status), .irq(irq), .dma_request(dma_request),
	.wake_request(wake_request));

//--- tb/icc_pin_source.sv
// External signal source at the capture pin.
// Assumes the bench calls toggle from its main process.
`timescale 1ns/10ps
module icc_pin_source (
	input wire logic clock,
	output logic pin
);
	initial pin = 1'b0;
	// Flips the pin after a falling edge and holds the level five cycles.
	task automatic toggle();
		@(negedge clock);
		pin <= ~pin;
		repeat (5) @(negedge clock);
	endtask
endmodule // icc_pin_source

//--- tb/input_capture_channel_test.sv
// Self-checking bench for the capture unit with a queue model.
// Assumes three channels sharing one pin source and one control word.
`timescale 1ns/10ps
module input_capture_channel_test;
	logic clock = 0;
	logic rstn = 0;
	logic pin, asleep = 0, ov, wake;
	logic [15:0] tb1 = 0, tb2 = 0;
	logic [15:0] q[$];
	logic [2:0] pop = 3'h0, clr = 3'h0, irq, dma;
	icc_pkg::icc_ctrl_s c = '0;
	icc_pkg::icc_stat_s [2:0] st;
	int fail_count = 0, tests_run = 0, seed = 38, irqs = 0, exp_irqs, wc, pc;
	int wakes = 0, exp_wakes, dmas = 0, stray_dma = 0;
	logic [15:0] w;
	always #10 clock = ~clock;
	icc_pin_source src (.clock(clock), .pin(pin));
	icc_unit #(.CHANNELS(3)) uut (.clock(clock), .rstn(rstn), .capture_input_pin({3{pin}}),
		.first_time_base(tb1), .second_time_base(tb2), .ctrl({3{c}}), .read_pop(pop),
		.overflow_clear(clr), .cpu_asleep(asleep), .status(st), .irq(irq),
		.dma_request(dma), .wake_request(wake));
	// Counts interrupt, DMA and wake pulses at the falling edge, where they are settled.
	always @(negedge clock) begin
		irqs <= irqs + irq[0];
		dmas <= dmas + dma[0];
		stray_dma <= stray_dma + dma[2];
		wakes <= wakes + wake;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		tests_run++;
		if (seen !== want) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Predicts capture, buffer and interrupt effects of one pin change.
	task automatic model(input logic lvl);
		logic cap;
		cap = 0;
		case (c.mode)
			3'h1: cap = 1;
			3'h2: cap = !lvl;
			3'h3, 3'h7: cap = lvl;
			3'h4, 3'h5: if (lvl) begin
				pc++;
				cap = (pc % (c.mode == 3'h4 ? 4 : 16)) == 0;
			end
			default: cap = 0;
		endcase
		if (cap && asleep) exp_wakes++;
		if (cap && c.mode == 3'h7) exp_irqs++;
		else if (cap && q.size() == 4) ov = 1;
		else if (cap) begin
			q.push_back(c.timer_select ? tb2 : tb1);
			wc++;
			if (wc == c.interrupt_count_select + 1) begin
				exp_irqs++;
				wc = 0;
			end
		end
	endtask
	// Walks mode codes 1 to 7 with random time bases, draining the buffer after each mode.
	initial begin
		repeat (5) @(negedge clock);
		rstn = 1;
		for (int m = 1; m < 8; m++) begin
			c.mode = icc_pkg::icc_mode_e'(3'(m));
			c.timer_select = 1'($random(seed));
			c.interrupt_count_select = 2'(m);
			asleep = 1'($random(seed));
			exp_irqs = irqs;
			exp_wakes = wakes;
			wc = 0;
			pc = 0;
			ov = 0;
			repeat (m[2] ? 34 : 10) begin
				tb1 = 16'($random(seed));
				tb2 = 16'($random(seed));
				src.toggle();
				model(pin);
			end
			check(16'(irqs), 16'(exp_irqs));
			check(16'(dmas), 16'(exp_irqs));
			check(16'(wakes), 16'(exp_wakes));
			check(st[0].capture_overflow_flag, ov);
			while (q.size() > 0) begin
				w = q.pop_front();
				check(st[0].read_data, w);
				check(st[2].read_data, w);
				pop = 3'h7;
				@(negedge clock);
				pop = 3'h0;
				@(negedge clock);
			end
			check(st[0].buffer_not_empty, 1'b0);
			pop = 3'h7;
			clr = 3'h7;
			@(negedge clock);
			pop = 3'h0;
			clr = 3'h0;
			c.mode = icc_pkg::ICC_MODE_OFF;
			repeat (2) @(negedge clock);
			check(st[0].capture_overflow_flag, 1'b0);
		end
		check(16'(stray_dma), 16'h0000);
		wrap_up();
	end
	// Cuts a hang short.
	initial begin
		#100_000;
		fail_count++;
		wrap_up();
	end
endmodule // input_capture_channel_test
